//--- hdl/mlec_pkg.sv
// package for the mode select and light effect control register bank
// assumes a single 250 MHz clock and a simple byte register port
package mlec_pkg;
  // ==========================================
  // register map and reset values
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h01;
  localparam logic [2:0] MODE_RESET = 3'h1;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================
  // light_effect_control field positions
  localparam int CTRL_LAST = 7;
  localparam int CTRL_ANALOG = 6;
  localparam int CTRL_STBY_HI = 5;
  localparam int CTRL_STBY_LO = 4;
  localparam int CTRL_ONTIME = 3;
  localparam int CTRL_TOUCH = 2;
  localparam int CTRL_PON = 1;
  localparam int CTRL_PON_SEQ = 0;

  localparam int NUM_OUT = 10;

  typedef enum logic [2:0] {
    MLEC_MODE_OPER = 3'b000,
    MLEC_MODE_LEDCFG = 3'b001,
    MLEC_MODE_DEVCFG = 3'b010,
    MLEC_MODE_TEST = 3'b011,
    MLEC_MODE_DEBUG = 3'b100
  } mlec_mode_t;

  // standby brightness in percent
  localparam logic [6:0] STBY_PCT_0 = 7'h00;
  localparam logic [6:0] STBY_PCT_20 = 7'h14;
  localparam logic [6:0] STBY_PCT_30 = 7'h1e;
  localparam logic [6:0] STBY_PCT_50 = 7'h32;

  // ==========================================
  // timing: one period step is 20 ms
  localparam longint STEP_TIME_NS = 20000000;
  localparam longint CLK_PERIOD_NS = 4;
  localparam int STEP_CYCLES_DEF = int'(STEP_TIME_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    MLEC_PON_IDLE = 2'b00,
    MLEC_PON_ALL = 2'b01,
    MLEC_PON_SEQ = 2'b10,
    MLEC_PON_DONE = 2'b11
  } mlec_pon_t;
endpackage

//--- hdl/mlec_hold_timer.sv
// per-output on-time after release, counted in period steps
// assumes tick is a one-cycle pulse every period step
`timescale 1ns/1ps
module mlec_hold_timer (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset, high
  input wire logic tick, // period step pulse
  input wire logic touched, // button currently touched
  input wire logic enable, // on-time enabled
  input wire logic [7:0] period, // on-time in steps
  output logic hold // output held on after release
);
  import mlec_pkg::*;

  logic touched_q;
  logic [7:0] count;
  logic next_touched_q;
  logic [7:0] next_count;
  logic next_hold;

  // ==========================================
  // countdown
  always_comb begin
    next_touched_q = touched;
    next_count = count;
    if (touched || !enable) begin
      next_count = 8'h00;
    end else if (touched_q) begin
      next_count = period;
    end else if (tick && count != 8'h00) begin
      next_count = count - 8'h01;
    end
    next_hold = (next_count != 8'h00);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      touched_q <= 1'b0;
      count <= 8'h00;
      hold <= 1'b0;
    end else begin
      touched_q <= next_touched_q;
      count <= next_count;
      hold <= next_hold;
    end
  end

  AST_HOLD_START: assert property (@(posedge clk) disable iff (srst)
    touched_q && !touched && enable && period != 8'h00 |=> hold && count == $past(period))
    else $error("on-time not started on release");
endmodule

//--- hdl/mlec_ctrl.sv
// mode select and light effect control registers with effect gating
// assumes a byte-wide register port fed by the serial host interface
`timescale 1ns/1ps
// Function
// - mode field codes 000..100 select the five modes; 101..111 invalid
// - power-on gives each register its initial value; reserved reads undefined
// - read-write registers accept writes and return contents on reads
// - bit 7 set limits touch effects to the most recently touched button
// - bit 6 allows outputs to act as open-drain analog switches
// - bits 5:4 set standby brightness 0, 20, 30 or 50 percent
// - bit 3 keeps LED on after release for first timing period
// - bit 2 enables touch effects; otherwise touch effect settings ignored; here the bit 3 on-time hold still runs with bit 2 clear
// - bit 1 enables power-on effects; otherwise their settings ignored
// - bit 0 runs power-on effects together or one by one 0..9
// - each timing period increment adds 20 ms to the effect time
module mlec_ctrl #(
  parameter int STEP_CYCLES = mlec_pkg::STEP_CYCLES_DEF // cycles per period step
) (
  input wire logic clk, // system clock, 250 MHz
  input wire logic srst, // synchronous reset, high
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data
  output logic reg_rvalid, // read data valid pulse
  input wire logic [mlec_pkg::NUM_OUT-1:0] touch, // button touch status
  input wire logic [7:0] first_global_timing_period, // on-time in steps
  input wire logic pon_start, // power-on effect start pulse
  input wire logic pon_step_done, // current power-on effect finished
  output logic [2:0] mode, // selected device mode
  output logic mode_valid, // mode code is a defined one
  output logic [4:0] mode_onehot, // one bit per defined mode
  output logic [mlec_pkg::NUM_OUT-1:0] touch_effect_en, // touch effect per output
  output logic [mlec_pkg::NUM_OUT-1:0] pon_effect_en, // power-on effect per output
  output logic pon_busy, // power-on effects running
  output logic [mlec_pkg::NUM_OUT-1:0] hold_on, // held on after release
  output logic touch_cfg_use, // touch effect settings in use
  output logic pon_cfg_use, // power-on effect settings in use
  output logic analog_out_en, // outputs may be analog switches
  output logic [6:0] standby_pct // standby brightness percent
);
  import mlec_pkg::*;

  logic [2:0] mode_r;
  logic [7:0] ctrl;
  logic [NUM_OUT-1:0] touch_q;
  logic [3:0] last_idx;
  logic last_vld;
  mlec_pon_t pon_state;
  logic [3:0] pon_idx;
  logic [22:0] step_cnt;
  logic tick;

  logic [2:0] next_mode_r;
  logic [7:0] next_ctrl;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic [NUM_OUT-1:0] next_touch_q;
  logic [3:0] next_last_idx;
  logic next_last_vld;
  mlec_pon_t next_pon_state;
  logic [3:0] next_pon_idx;
  logic [22:0] next_step_cnt;
  logic next_tick;
  logic [4:0] next_mode_onehot;
  logic next_mode_valid;
  logic [NUM_OUT-1:0] next_touch_eff;
  logic [NUM_OUT-1:0] next_pon_eff;
  logic [6:0] next_stby;

  // ==========================================
  // register port
  always_comb begin
    next_mode_r = mode_r;
    next_ctrl = ctrl;
    next_rdata = reg_rdata;
    next_rvalid = reg_rd;
    if (reg_wr && reg_addr == ADDR_MODE) begin
      next_mode_r = reg_wdata[2:0];
    end
    if (reg_wr && reg_addr == ADDR_CTRL) begin
      next_ctrl = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_MODE: next_rdata = {5'h00, mode_r};
        ADDR_CTRL: next_rdata = ctrl;
        // reserved locations hold nothing; zero is returned
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // ==========================================
  // mode decode
  always_comb begin
    next_mode_valid = (next_mode_r <= 3'h4);
    next_mode_onehot = 5'h00;
    case (next_mode_r)
      MLEC_MODE_OPER: next_mode_onehot = 5'h01;
      MLEC_MODE_LEDCFG: next_mode_onehot = 5'h02;
      MLEC_MODE_DEVCFG: next_mode_onehot = 5'h04;
      MLEC_MODE_TEST: next_mode_onehot = 5'h08;
      MLEC_MODE_DEBUG: next_mode_onehot = 5'h10;
      default: next_mode_onehot = 5'h00;
    endcase
  end

  // ==========================================
  // period step divider, shared by all hold timers
  always_comb begin
    next_tick = 1'b0;
    if (step_cnt == 23'(STEP_CYCLES - 1)) begin
      next_step_cnt = 23'h0;
      next_tick = 1'b1;
    end else begin
      next_step_cnt = step_cnt + 23'h1;
    end
  end

  // ==========================================
  // touch effects and last touched button
  always_comb begin
    next_touch_q = touch;
    next_last_idx = last_idx;
    next_last_vld = last_vld;
    // simultaneous rises: highest index wins, an arbitrary but stable pick
    for (int i = 0; i < NUM_OUT; i++) begin
      if (touch[i] && !touch_q[i]) begin
        next_last_idx = 4'(i);
        next_last_vld = 1'b1;
      end
    end
    next_touch_eff = 10'h000;
    if (next_ctrl[CTRL_TOUCH]) begin
      if (next_ctrl[CTRL_LAST]) begin
        if (next_last_vld) begin
          next_touch_eff = touch & (10'h001 << next_last_idx);
        end
      end else begin
        next_touch_eff = touch;
      end
    end
    case (next_ctrl[CTRL_STBY_HI:CTRL_STBY_LO])
      2'b00: next_stby = STBY_PCT_0;
      2'b01: next_stby = STBY_PCT_20;
      2'b10: next_stby = STBY_PCT_30;
      default: next_stby = STBY_PCT_50;
    endcase
  end

  // ==========================================
  // power-on effect sequencer
  always_comb begin
    next_pon_state = pon_state;
    next_pon_idx = pon_idx;
    case (pon_state)
      MLEC_PON_IDLE: begin
        if (pon_start) begin
          next_pon_idx = 4'h0;
          if (!ctrl[CTRL_PON]) begin
            next_pon_state = MLEC_PON_DONE;
          end else if (ctrl[CTRL_PON_SEQ]) begin
            next_pon_state = MLEC_PON_SEQ;
          end else begin
            next_pon_state = MLEC_PON_ALL;
          end
        end
      end
      MLEC_PON_ALL: begin
        if (pon_step_done) begin
          next_pon_state = MLEC_PON_DONE;
        end
      end
      MLEC_PON_SEQ: begin
        if (pon_step_done) begin
          if (pon_idx == 4'(NUM_OUT - 1)) begin
            next_pon_state = MLEC_PON_DONE;
          end else begin
            next_pon_idx = pon_idx + 4'h1;
          end
        end
      end
      default: next_pon_state = pon_state;
    endcase
    case (next_pon_state)
      MLEC_PON_ALL: next_pon_eff = 10'h3ff;
      MLEC_PON_SEQ: next_pon_eff = 10'h001 << next_pon_idx;
      default: next_pon_eff = 10'h000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_r <= MODE_RESET;
      ctrl <= CTRL_RESET;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      mode_valid <= 1'b1;
      mode_onehot <= 5'h02;
      step_cnt <= 23'h0;
      tick <= 1'b0;
      touch_q <= 10'h000;
      last_idx <= 4'h0;
      last_vld <= 1'b0;
      touch_effect_en <= 10'h000;
      standby_pct <= STBY_PCT_0;
      analog_out_en <= 1'b0;
      touch_cfg_use <= 1'b0;
      pon_cfg_use <= 1'b0;
      pon_state <= MLEC_PON_IDLE;
      pon_idx <= 4'h0;
      pon_effect_en <= 10'h000;
      pon_busy <= 1'b0;
    end else begin
      mode_r <= next_mode_r;
      ctrl <= next_ctrl;
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
      mode_valid <= next_mode_valid;
      mode_onehot <= next_mode_onehot;
      step_cnt <= next_step_cnt;
      tick <= next_tick;
      touch_q <= next_touch_q;
      last_idx <= next_last_idx;
      last_vld <= next_last_vld;
      touch_effect_en <= next_touch_eff;
      standby_pct <= next_stby;
      analog_out_en <= next_ctrl[CTRL_ANALOG];
      touch_cfg_use <= next_ctrl[CTRL_TOUCH];
      pon_cfg_use <= next_ctrl[CTRL_PON];
      pon_state <= next_pon_state;
      pon_idx <= next_pon_idx;
      pon_effect_en <= next_pon_eff;
      pon_busy <= (next_pon_state == MLEC_PON_ALL) || (next_pon_state == MLEC_PON_SEQ);
    end
  end

  assign mode = mode_r;

  // ==========================================
  // on-time after release, one timer per output
  for (genvar g = 0; g < NUM_OUT; g++) begin : gen_hold
    mlec_hold_timer u_hold (
      .clk(clk),
      .srst(srst),
      .tick(tick),
      .touched(touch[g]),
      .enable(ctrl[CTRL_ONTIME]),
      .period(first_global_timing_period),
      .hold(hold_on[g])
    );
  end

  // ==========================================
  // checks
  AST_RESET_VALUES: assert property (@(posedge clk) $fell(srst) |->
    mode == MODE_RESET && ctrl == CTRL_RESET && !pon_busy)
    else $error("registers not at initial value after reset");
  AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (srst)
    reg_wr && reg_addr == ADDR_CTRL |=> ctrl == $past(reg_wdata))
    else $error("control write not stored");
  AST_MODE_READ: assert property (@(posedge clk) disable iff (srst)
    reg_rd && reg_addr == ADDR_MODE |=> reg_rvalid && reg_rdata == {5'h00, $past(mode_r)})
    else $error("mode read returned wrong value");
  AST_MODE_DECODE: assert property (@(posedge clk) disable iff (srst)
    mode_r == MLEC_MODE_DEBUG |-> mode_onehot == 5'h10 && mode_valid)
    else $error("debug mode not decoded");
  AST_LAST_ONLY: assert property (@(posedge clk) disable iff (srst)
    ctrl[CTRL_LAST] |-> $countones(touch_effect_en) <= 1)
    else $error("touch effect on more than one output");
  AST_ANALOG: assert property (@(posedge clk) disable iff (srst)
    reg_wr && reg_addr == ADDR_CTRL |=> analog_out_en == $past(reg_wdata[CTRL_ANALOG]))
    else $error("analog enable does not follow control");
  AST_STANDBY: assert property (@(posedge clk) disable iff (srst)
    ctrl[CTRL_STBY_HI:CTRL_STBY_LO] == 2'b11 |-> standby_pct == STBY_PCT_50)
    else $error("standby brightness wrong");
  AST_TOUCH_OFF: assert property (@(posedge clk) disable iff (srst)
    !ctrl[CTRL_TOUCH] |-> touch_effect_en == 10'h000 && !touch_cfg_use)
    else $error("touch effect while disabled");
  AST_PON_OFF: assert property (@(posedge clk) disable iff (srst)
    pon_state == MLEC_PON_IDLE && pon_start && !ctrl[CTRL_PON] |=> pon_state == MLEC_PON_DONE && !pon_busy)
    else $error("power-on effect ran while disabled");
  AST_PON_SEQ: assert property (@(posedge clk) disable iff (srst)
    pon_state == MLEC_PON_SEQ |-> $onehot(pon_effect_en) && pon_effect_en == (10'h001 << pon_idx))
    else $error("sequential power-on not one output");
  AST_STEP_TICK: assert property (@(posedge clk) disable iff (srst)
    tick |-> step_cnt == 23'h0)
    else $error("step tick at wrong count");
endmodule

//--- dv/mlec_host_model.sv
// host side model driving the byte register port of the control bank
// assumes one calling process and a free running clk
`timescale 1ns/1ps
module mlec_host_model (
  input wire logic clk, // system clock
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic [7:0] reg_addr, // register address
  output logic [7:0] reg_wdata, // write data
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_rvalid // read data valid
);
  import mlec_pkg::*;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // ==========================================
  // bus cycles
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // idle strobes drop low and address and data show the inverse of the last value, so nothing stale reads as valid
  task automatic release_bus();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    // invalid mode codes are never sent
    if (addr == ADDR_MODE && data[2:0] > 3'h4) begin
      return;
    end
    step();
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    step();
    release_bus();
  endtask
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int n;
    step();
    reg_addr = addr;
    reg_rd = 1'b1;
    step();
    release_bus();
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      step();
      n++;
    end
    ok = (reg_rvalid === 1'b1);
    data = reg_rdata;
  endtask
endmodule

//--- dv/tb_top.sv
// self-checking bench for the mode select and light effect control bank
// assumes the host model above and a shortened period step
`timescale 1ns/1ps
module tb_top;
  import mlec_pkg::*;
  localparam int STEPS = 8;
  localparam int LIMIT = 4000;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid, rd_ok;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_data;
  logic [NUM_OUT-1:0] touch = '0;
  logic [7:0] period = 8'h00;
  logic pon_start = 1'b0;
  logic pon_step_done = 1'b0;
  logic [2:0] mode;
  logic [4:0] mode_onehot;
  logic [NUM_OUT-1:0] touch_effect_en, pon_effect_en, hold_on;
  logic mode_valid, pon_busy, touch_cfg_use, pon_cfg_use, analog_out_en;
  logic [6:0] standby_pct;
  logic [6:0] stby_tab [4] = '{STBY_PCT_0, STBY_PCT_20, STBY_PCT_30, STBY_PCT_50};
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  mlec_host_model mlec_host_model_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  mlec_ctrl #(.STEP_CYCLES(STEPS)) mlec_ctrl_i (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .touch(touch), .first_global_timing_period(period), .pon_start(pon_start),
    .pon_step_done(pon_step_done), .mode(mode), .mode_valid(mode_valid), .mode_onehot(mode_onehot),
    .touch_effect_en(touch_effect_en), .pon_effect_en(pon_effect_en), .pon_busy(pon_busy),
    .hold_on(hold_on), .touch_cfg_use(touch_cfg_use), .pon_cfg_use(pon_cfg_use),
    .analog_out_en(analog_out_en), .standby_pct(standby_pct));
  // ==========================================
  // helpers
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic reg_chk(input logic [7:0] addr, input logic [7:0] exp);
    mlec_host_model_i.read_reg(addr, rd_data, rd_ok);
    chk("reg_rvalid", 16'(rd_ok), 16'h0001);
    chk("reg_rdata", 16'(rd_data), 16'(exp));
  endtask
  // outputs may sit one flop behind the register, so let one more edge pass
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    mlec_host_model_i.write_reg(addr, data);
    step(1);
  endtask
  task automatic do_reset();
    srst = 1'b1;
    step(6);
    srst = 1'b0;
  endtask
  task automatic pulse_start();
    pon_start = 1'b1;
    step(1);
    pon_start = 1'b0;
  endtask
  task automatic pulse_done();
    pon_step_done = 1'b1;
    step(1);
    pon_step_done = 1'b0;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      end_sim();
    end
  end
  // ==========================================
  // scenarios
  initial begin
    do_reset();
    reg_chk(ADDR_MODE, 8'h01);
    reg_chk(ADDR_CTRL, 8'h00);
    chk("mode_onehot", 16'(mode_onehot), 16'h0002);
    reg_chk(8'h05, 8'h00);
    for (int m = 0; m < 5; m++) begin
      wr(ADDR_MODE, 8'(m));
      chk("mode", 16'(mode), 16'(m));
      chk("mode_onehot", 16'(mode_onehot), 16'(1 << m));
      chk("mode_valid", 16'(mode_valid), 16'h0001);
      reg_chk(ADDR_MODE, 8'(m));
    end
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CTRL, {2'b01, 2'(s), 4'h0});
      chk("standby_pct", 16'(standby_pct), 16'(stby_tab[s]));
      chk("analog_out_en", 16'(analog_out_en), 16'h0001);
      reg_chk(ADDR_CTRL, {2'b01, 2'(s), 4'h0});
    end
    wr(ADDR_CTRL, 8'h04);
    chk("analog_out_en", 16'(analog_out_en), 16'h0000);
    touch = 10'h00a;
    step(2);
    chk("touch_effect_en", 16'(touch_effect_en), 16'h000a);
    chk("touch_cfg_use", 16'(touch_cfg_use), 16'h0001);
    wr(ADDR_CTRL, 8'h84);
    touch = 10'h02a;
    step(2);
    chk("touch_effect_en", 16'(touch_effect_en), 16'h0020);
    wr(ADDR_CTRL, 8'h00);
    chk("touch_effect_en", 16'(touch_effect_en), 16'h0000);
    chk("touch_cfg_use", 16'(touch_cfg_use), 16'h0000);
    touch = '0;
    wr(ADDR_CTRL, 8'h0c);
    period = 8'h02;
    touch = 10'h008;
    step(2);
    touch = '0;
    step(2);
    chk("hold_on", 16'(hold_on), 16'h0008);
    step(STEPS - 2);
    chk("hold_on", 16'(hold_on), 16'h0008);
    step(2 * STEPS);
    chk("hold_on", 16'(hold_on), 16'h0000);
    wr(ADDR_CTRL, 8'h04);
    touch = 10'h008;
    step(2);
    touch = '0;
    step(2);
    chk("hold_on", 16'(hold_on), 16'h0000);
    // power-on runs once per reset, so each variant gets its own
    do_reset();
    wr(ADDR_CTRL, 8'h03);
    pulse_start();
    chk("pon_busy", 16'(pon_busy), 16'h0001);
    chk("pon_cfg_use", 16'(pon_cfg_use), 16'h0001);
    for (int k = 0; k < NUM_OUT; k++) begin
      chk("pon_effect_en", 16'(pon_effect_en), 16'(1 << k));
      pulse_done();
    end
    chk("pon_busy", 16'(pon_busy), 16'h0000);
    chk("pon_effect_en", 16'(pon_effect_en), 16'h0000);
    do_reset();
    wr(ADDR_CTRL, 8'h02);
    pulse_start();
    chk("pon_effect_en", 16'(pon_effect_en), 16'h03ff);
    pulse_done();
    chk("pon_busy", 16'(pon_busy), 16'h0000);
    do_reset();
    wr(ADDR_CTRL, 8'h01);
    pulse_start();
    chk("pon_busy", 16'(pon_busy), 16'h0000);
    chk("pon_effect_en", 16'(pon_effect_en), 16'h0000);
    chk("pon_cfg_use", 16'(pon_cfg_use), 16'h0000);
    end_sim();
  end
endmodule
